// file: design/aimr_regs.sv
// record-path input mix routing registers with left adc gain soft-stepper
`timescale 1ns/1ns
// Overview of operation
// - A level code 0000..1000 sets mixer attenuation 0 dB to -12 dB in -1.5 dB steps.
// - Level code 1111 disconnects the input, and every level field resets to 1111.
// - Any valid level code connects its input to the mixer with no extra enable.
// - Register 0x11 holds left-second level in D7-D4 and right-second level in D3-D0.
// - Register 0x12 holds the same two fields for the right mixer.
// - Register 0x13 bit D7 selects single-ended (0) or differential (1), reset 0.
// - Register 0x13 bits D6-D3 route the first left input to the left mixer, reset 1111.
// - Register 0x13 bit D2 powers the left adc channel, reset 0 meaning powered down.
// - Register 0x13 bits D1-D0 pick stepping per sample, per two samples, or none.
// - The left adc gain is a 7-bit code of 0.5 dB steps from 0 dB.
module aimr_regs (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register port from the control bus engine
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   // gain target and sample-rate tick
   input wire logic [6:0] gain_target,
   input wire logic sample_tick,
   // decoded routing: 0 l2->L, 1 >L, 2 l2->R, 3 >R, 4 l1->L
   output logic [4:0] mix_connect,
   output logic [4:0][4:0] mix_atten_hdb,
   // first left input mode, channel power, applied gain
   output logic first_left_diff,
   output logic adc_left_power,
   output logic [6:0] gain_applied
);
   logic [7:0] reg_second_left;
   logic [7:0] reg_second_right;
   logic [7:0] reg_first;
   logic [7:0] next_reg_second_left;
   logic [7:0] next_reg_second_right;
   logic [7:0] next_reg_first;
   logic [7:0] next_reg_rdata;
   logic next_reg_rvalid;
   logic [4:0] next_mix_connect;
   logic [4:0][4:0] next_mix_atten_hdb;
   logic next_first_left_diff;
   logic next_adc_left_power;
   logic [6:0] next_gain_applied;
   logic step_phase;
   logic next_step_phase;
   logic [1:0] step_mode;
   logic [3:0] lvl_code [aimr_pkg::NUM_LVL];

   aimr_lvl_if lvl [aimr_pkg::NUM_LVL] ();

   // register writes; reserved codes are stored as written
   always_comb begin
      next_reg_second_left = reg_second_left;
      next_reg_second_right = reg_second_right;
      next_reg_first = reg_first;
      if (reg_wr) begin
         unique case (reg_addr)
            aimr_pkg::OFS_SECOND_TO_LEFT: next_reg_second_left = reg_wdata;
            aimr_pkg::OFS_SECOND_TO_RIGHT: next_reg_second_right = reg_wdata;
            aimr_pkg::OFS_FIRST_LEFT: next_reg_first = reg_wdata;
            default: ;
         endcase
      end
   end

   // register readback, unmapped addresses read zero
   always_comb begin
      next_reg_rvalid = reg_rd;
      next_reg_rdata = aimr_pkg::RST_READ_DATA;
      if (reg_rd) begin
         unique case (reg_addr)
            aimr_pkg::OFS_SECOND_TO_LEFT: next_reg_rdata = reg_second_left;
            aimr_pkg::OFS_SECOND_TO_RIGHT: next_reg_rdata = reg_second_right;
            aimr_pkg::OFS_FIRST_LEFT: next_reg_rdata = reg_first;
            default: next_reg_rdata = aimr_pkg::RST_READ_DATA;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         reg_second_left <= aimr_pkg::RST_SECOND_TO_LEFT;
         reg_second_right <= aimr_pkg::RST_SECOND_TO_RIGHT;
         reg_first <= aimr_pkg::RST_FIRST_LEFT;
         reg_rdata <= aimr_pkg::RST_READ_DATA;
         reg_rvalid <= 1'b0;
      end else begin
         reg_second_left <= next_reg_second_left;
         reg_second_right <= next_reg_second_right;
         reg_first <= next_reg_first;
         reg_rdata <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end

   // field extraction for the five level decoders
   assign lvl_code[0] = reg_second_left[aimr_pkg::LVL_HI_MSB:aimr_pkg::LVL_HI_LSB];
   assign lvl_code[1] = reg_second_left[aimr_pkg::LVL_LO_MSB:aimr_pkg::LVL_LO_LSB];
   assign lvl_code[2] = reg_second_right[aimr_pkg::LVL_HI_MSB:aimr_pkg::LVL_HI_LSB];
   assign lvl_code[3] = reg_second_right[aimr_pkg::LVL_LO_MSB:aimr_pkg::LVL_LO_LSB];
   assign lvl_code[4] = reg_first[aimr_pkg::FIRST_LVL_MSB:aimr_pkg::FIRST_LVL_LSB];

   // one decoder per level field
   for (genvar i = 0; i < aimr_pkg::NUM_LVL; i++) begin : g_lvl
      assign lvl[i].code = lvl_code[i];
      aimr_lvl_decode u_dec (
         .lvl (lvl[i])
      );
      assign next_mix_connect[i] = lvl[i].connect;
      assign next_mix_atten_hdb[i] = lvl[i].atten_hdb;
   end

   // mode and power bits feed the analog side through the output register below
   assign next_first_left_diff = reg_first[aimr_pkg::FIRST_DIFF_BIT];
   assign next_adc_left_power = reg_first[aimr_pkg::FIRST_POWER_BIT];
   assign step_mode = reg_first[aimr_pkg::FIRST_STEP_MSB:aimr_pkg::FIRST_STEP_LSB];

   // routing outputs registered so the analog controls never glitch
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mix_connect <= '0;
         mix_atten_hdb <= '0;
         first_left_diff <= 1'b0;
         adc_left_power <= 1'b0;
      end else begin
         mix_connect <= next_mix_connect;
         mix_atten_hdb <= next_mix_atten_hdb;
         first_left_diff <= next_first_left_diff;
         adc_left_power <= next_adc_left_power;
      end
   end

   // gain soft-stepper; the phase bit halves the rate in mode 01
   always_comb begin
      next_gain_applied = gain_applied;
      next_step_phase = step_phase;
      if (step_mode != aimr_pkg::STEP_EVERY_SAMPLE && step_mode != aimr_pkg::STEP_EVERY_TWO) begin
         next_gain_applied = gain_target;
         next_step_phase = 1'b0;
      end else if (sample_tick) begin
         if (step_mode == aimr_pkg::STEP_EVERY_TWO && !step_phase) begin
            next_step_phase = 1'b1;
         end else begin
            next_step_phase = 1'b0;
            // one 0.5 dB code step toward the target
            if (gain_applied < gain_target) begin
               next_gain_applied = 7'(gain_applied + 7'h01);
            end else if (gain_applied > gain_target) begin
               next_gain_applied = 7'(gain_applied - 7'h01);
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         gain_applied <= aimr_pkg::RST_GAIN;
         step_phase <= 1'b0;
      end else begin
         gain_applied <= next_gain_applied;
         step_phase <= next_step_phase;
      end
   end

   // a write of a valid level code to the left-mix register
   sequence s_wr_valid_left_hi;
      reg_wr && reg_addr == aimr_pkg::OFS_SECOND_TO_LEFT && reg_wdata[7:4] <= 4'h8;
   endsequence

   // two samples of a below-target gain in every-two mode, target held
   sequence s_two_ticks_up;
      (sample_tick && step_mode == 2'h1 && !step_phase && gain_applied < gain_target
       && $stable(gain_target)) ##1 (!sample_tick [*1]) ##1
      (sample_tick && gain_applied < gain_target && step_mode == 2'h1 && $stable(gain_target));
   endsequence

   AST_RESET_FIELDS: assert property (@(posedge clock)
      $past(sys_rst) |-> reg_second_left == 8'hff && reg_second_right == 8'hff
         && reg_first == 8'h78)
      else $error("level fields or first register not at reset value");

   AST_ATTEN_MAP: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_second_left[7:4] <= 4'h8) |=>
         mix_atten_hdb[0] == 5'({1'b0, $past(reg_second_left[7:4])}
         + {$past(reg_second_left[7:4]), 1'b0}))
      else $error("attenuation does not follow level code");

   AST_OFF_CODE: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_second_right[3:0] == 4'hf) |=> !mix_connect[3])
      else $error("input connected while its level code is off");

   AST_WRITE_CONNECTS: assert property (@(posedge clock) disable iff (sys_rst)
      s_wr_valid_left_hi |=> ##1 mix_connect[0])
      else $error("valid level write did not connect the input");

   AST_RIGHT_REG_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_wr && reg_addr == 8'h12) |=> reg_second_right == $past(reg_wdata)
         ##1 mix_connect[2] == ($past(reg_second_right[7:4]) <= 4'h8))
      else $error("right mix register write or decode wrong");

   AST_FIRST_FIELDS: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_wr && reg_addr == 8'h13) |=> ##1 first_left_diff == $past(reg_wdata[7], 2)
         && adc_left_power == $past(reg_wdata[2], 2)
         && mix_connect[4] == ($past(reg_wdata[6:3], 2) <= 4'h8))
      else $error("first left input fields not applied");

   AST_READBACK: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_rd && reg_addr == 8'h11) |=> reg_rvalid && reg_rdata == $past(reg_second_left))
      else $error("readback of left mix register wrong");

   AST_STEP_EVERY_SAMPLE: assert property (@(posedge clock) disable iff (sys_rst)
      (sample_tick && step_mode == 2'h0 && gain_applied > gain_target) |=>
         gain_applied == 7'($past(gain_applied) - 7'h01))
      else $error("gain did not step down once per sample");

   AST_STEP_EVERY_TWO: assert property (@(posedge clock) disable iff (sys_rst)
      s_two_ticks_up |=> gain_applied == 7'($past(gain_applied, 3) + 7'h01))
      else $error("gain did not step once per two samples");

   AST_STEP_OFF: assert property (@(posedge clock) disable iff (sys_rst)
      (step_mode[1]) |=> gain_applied == $past(gain_target))
      else $error("gain not applied at once with stepping off");

   // accesses to an address outside the three mapped registers
   sequence s_wr_unmapped;
      reg_wr && reg_addr != aimr_pkg::OFS_SECOND_TO_LEFT
         && reg_addr != aimr_pkg::OFS_SECOND_TO_RIGHT
         && reg_addr != aimr_pkg::OFS_FIRST_LEFT;
   endsequence

   sequence s_rd_unmapped;
      reg_rd && reg_addr != aimr_pkg::OFS_SECOND_TO_LEFT
         && reg_addr != aimr_pkg::OFS_SECOND_TO_RIGHT
         && reg_addr != aimr_pkg::OFS_FIRST_LEFT;
   endsequence

   // the other level fields share the code map of field 0
   AST_LEFT_LOW_MAP: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_second_left[3:0] <= 4'h8) |=> mix_connect[1]
         && mix_atten_hdb[1] == 5'({1'b0, $past(reg_second_left[3:0])}
         + {$past(reg_second_left[3:0]), 1'b0}))
      else $error("left mix low field decode wrong");

   AST_RIGHT_HI_MAP: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_second_right[7:4] <= 4'h8) |=> mix_connect[2]
         && mix_atten_hdb[2] == 5'({1'b0, $past(reg_second_right[7:4])}
         + {$past(reg_second_right[7:4]), 1'b0}))
      else $error("right mix high field decode wrong");

   AST_RIGHT_LOW_MAP: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_second_right[3:0] <= 4'h8) |=> mix_connect[3]
         && mix_atten_hdb[3] == 5'({1'b0, $past(reg_second_right[3:0])}
         + {$past(reg_second_right[3:0]), 1'b0}))
      else $error("right mix low field decode wrong");

   AST_FIRST_MIX_MAP: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_first[6:3] <= 4'h8) |=> mix_connect[4]
         && mix_atten_hdb[4] == 5'({1'b0, $past(reg_first[6:3])}
         + {$past(reg_first[6:3]), 1'b0}))
      else $error("first left input decode wrong");

   // codes above 1000 never connect, whether off or reserved
   AST_HIGH_CODES_OPEN: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_second_left[3:0] > 4'h8) |=> !mix_connect[1] && mix_atten_hdb[1] == 5'h00)
      else $error("input connected with a code above the valid range");

   AST_LEFT_REG_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_wr && reg_addr == 8'h11) |=> reg_second_left == $past(reg_wdata))
      else $error("left mix register write not stored");

   AST_FIRST_REG_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
      (reg_wr && reg_addr == 8'h13) |=> reg_first == $past(reg_wdata))
      else $error("first left register write not stored");

   AST_UNMAPPED_WRITE: assert property (@(posedge clock) disable iff (sys_rst)
      s_wr_unmapped |=> $stable(reg_second_left) && $stable(reg_second_right)
         && $stable(reg_first))
      else $error("write to an unmapped address changed a register");

   AST_UNMAPPED_READ: assert property (@(posedge clock) disable iff (sys_rst)
      s_rd_unmapped |=> reg_rvalid && reg_rdata == 8'h00)
      else $error("unmapped read did not answer zero");

   AST_READ_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
      !reg_rd |=> !reg_rvalid && reg_rdata == 8'h00)
      else $error("read answer without a read strobe");

   // the channel must come out of reset powered down with nothing routed
   AST_RESET_OUTPUTS: assert property (@(posedge clock)
      $past(sys_rst) |-> !adc_left_power && !first_left_diff && mix_connect == 5'h00
         && gain_applied == 7'h00 && !reg_rvalid)
      else $error("outputs not at reset value");

   AST_MODE_POWER_FOLLOW: assert property (@(posedge clock) disable iff (sys_rst)
      1'b1 |=> first_left_diff == $past(reg_first[7])
         && adc_left_power == $past(reg_first[2]))
      else $error("mode or power output does not follow its bit");

   AST_STEP_UP_EVERY_SAMPLE: assert property (@(posedge clock) disable iff (sys_rst)
      (sample_tick && step_mode == 2'h0 && gain_applied < gain_target) |=>
         gain_applied == 7'($past(gain_applied) + 7'h01))
      else $error("gain did not step up once per sample");

   AST_PHASE_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
      (sample_tick && step_mode == 2'h1 && !step_phase) |=> $stable(gain_applied))
      else $error("gain moved on the first tick of a pair");

   AST_NO_TICK_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
      (!sample_tick && !step_mode[1]) |=> $stable(gain_applied))
      else $error("gain moved without a sample tick");
endmodule : aimr_regs

// file: design/aimr_pkg.sv
// shared constants for the adc input mix routing register group
package aimr_pkg;
   // register offsets (page 0 register numbers)
   localparam logic [7:0] OFS_SECOND_TO_LEFT = 8'h11;
   localparam logic [7:0] OFS_SECOND_TO_RIGHT = 8'h12;
   localparam logic [7:0] OFS_FIRST_LEFT = 8'h13;
   // values after reset
   localparam logic [7:0] RST_SECOND_TO_LEFT = 8'hff;
   localparam logic [7:0] RST_SECOND_TO_RIGHT = 8'hff;
   localparam logic [7:0] RST_FIRST_LEFT = 8'h78;
   localparam logic [7:0] RST_READ_DATA = 8'h00;
   localparam logic [6:0] RST_GAIN = 7'h00;
   // field positions in the second-input registers
   localparam int LVL_HI_MSB = 7;
   localparam int LVL_HI_LSB = 4;
   localparam int LVL_LO_MSB = 3;
   localparam int LVL_LO_LSB = 0;
   // field positions in the first-left-input register
   localparam int FIRST_DIFF_BIT = 7;
   localparam int FIRST_LVL_MSB = 6;
   localparam int FIRST_LVL_LSB = 3;
   localparam int FIRST_POWER_BIT = 2;
   localparam int FIRST_STEP_MSB = 1;
   localparam int FIRST_STEP_LSB = 0;
   // input level codes
   localparam logic [3:0] LVL_MAX_VALID = 4'h8;
   localparam logic [3:0] LVL_OFF = 4'hf;
   // attenuation per code step in half-dB units (1.5 dB)
   localparam logic [4:0] LVL_STEP_HDB = 5'h03;
   // soft-stepping modes
   localparam logic [1:0] STEP_EVERY_SAMPLE = 2'h0;
   localparam logic [1:0] STEP_EVERY_TWO = 2'h1;
   // number of level fields decoded
   localparam int NUM_LVL = 5;
endpackage : aimr_pkg

// file: design/aimr_lvl_if.sv
// carrier between a level register field and its decoder
`timescale 1ns/1ns
interface aimr_lvl_if;
   logic [3:0] code;
   logic connect;
   logic [4:0] atten_hdb;
   modport dec (input code, output connect, output atten_hdb);
   modport user (output code, input connect, input atten_hdb);
endinterface : aimr_lvl_if

// file: design/aimr_lvl_decode.sv
// decoder of one 4-bit input level field into connect and attenuation
`timescale 1ns/1ns
module aimr_lvl_decode #(
   parameter logic [4:0] STEP_HDB = aimr_pkg::LVL_STEP_HDB
) (
   // field in, decoded level out
   aimr_lvl_if.dec lvl
);
   logic [4:0] prod;

   // code times step; codes above 8 never reach the mixer
   always_comb begin
      prod = 5'h00;
      for (int k = 0; k < 4; k++) begin
         if (lvl.code[k]) begin
            prod = 5'(prod + (STEP_HDB << k));
         end
      end
      if (lvl.code <= aimr_pkg::LVL_MAX_VALID) begin
         lvl.connect = 1'b1;
         lvl.atten_hdb = prod;
      end else begin
         // 1111 and reserved codes both leave the input open
         lvl.connect = 1'b0;
         lvl.atten_hdb = 5'h00;
      end
   end
endmodule : aimr_lvl_decode

// file: dv/aimr_host.sv
// host model issuing register writes and reads on the strobe port
`timescale 1ns/1ns
module aimr_host (
   // clock
   input wire logic clock,
   // strobe port toward the registers
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   // idle bus starts at zero, then shows the flipped address after each access and flipped data after each write so a stale address is never trusted
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // one-cycle write; reserved level codes only when a test asks for them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr

   // one-cycle read; the answer is picked up by the bench monitor
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask : rd
endmodule : aimr_host

// file: dv/aimr_regs_tb_top.sv
// self-checking bench for the input mix routing registers and gain stepper
`timescale 1ns/1ns
module aimr_regs_tb_top;
   logic clock;
   logic sys_rst;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   logic [6:0] gain_target;
   logic sample_tick;
   logic [4:0] mix_connect;
   logic [4:0][4:0] mix_atten_hdb;
   logic first_left_diff;
   logic adc_left_power;
   logic [6:0] gain_applied;
   logic [7:0] exp_q[$];
   logic [3:0] code[5];
   logic [7:0] r13;
   int failures;
   int checks;

   aimr_regs DUT (.clock(clock), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .gain_target(gain_target), .sample_tick(sample_tick),
      .mix_connect(mix_connect), .mix_atten_hdb(mix_atten_hdb),
      .first_left_diff(first_left_diff), .adc_left_power(adc_left_power),
      .gain_applied(gain_applied));
   aimr_host host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata));

   // 100 MHz clock
   initial clock = 1'b0;
   always #5 clock = ~clock;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict

   // note the expected answer, then issue the read
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask : rd

   // decoded outputs lag a write by two edges, so wait three
   task automatic settle();
      repeat (3) @(posedge clock);
      #1;
   endtask : settle

   task automatic chk_route();
      for (int i = 0; i < 5; i++) begin
         chk(mix_connect[i], code[i] <= 4'h8);
         chk(mix_atten_hdb[i], (code[i] <= 4'h8) ? code[i] * 32'h3 : 32'h0);
      end
   endtask : chk_route

   // one sample tick, then the applied gain is compared
   task automatic tick(input logic [6:0] e);
      @(posedge clock);
      sample_tick <= 1'b1;
      @(posedge clock);
      sample_tick <= 1'b0;
      settle();
      chk(gain_applied, e);
   endtask : tick

   // two ticks one idle cycle apart, then the applied gain is compared
   task automatic tick_pair(input logic [6:0] e);
      @(posedge clock);
      sample_tick <= 1'b1;
      @(posedge clock);
      sample_tick <= 1'b0;
      @(posedge clock);
      sample_tick <= 1'b1;
      @(posedge clock);
      sample_tick <= 1'b0;
      settle();
      chk(gain_applied, e);
   endtask : tick_pair

   // each read answer is matched against the oldest note
   always @(posedge clock) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("mismatch at %0t: read answer nobody asked for", $time);
         end else begin
            chk(reg_rdata, exp_q.pop_front());
         end
      end
   end

   // watchdog, far beyond the few hundred cycles (about 350) the run needs
   initial begin
      repeat (20000) @(posedge clock);
      failures++;
      give_verdict();
   end

   initial begin
      sys_rst = 1'b1;
      gain_target = 7'h00;
      sample_tick = 1'b0;
      failures = 0;
      checks = 0;
      void'($urandom(28453));
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      settle();
      for (int i = 0; i < 5; i++) code[i] = 4'hf;
      chk_route();
      chk({first_left_diff, adc_left_power}, 2'h0);
      rd(8'h11, 8'hff);
      rd(8'h12, 8'hff);
      rd(8'h13, 8'h78);
      // every valid code and the off code land in some field, the rest random valid codes
      for (int c = 0; c < 16; c++) begin
         for (int i = 0; i < 5; i++) code[i] = 4'($urandom_range(8, 0));
         code[c % 5] = (c > 8) ? 4'hf : 4'(c);
         r13 = {1'($urandom), code[4], 1'($urandom), 2'($urandom)};
         host.wr(8'h11, {code[0], code[1]});
         host.wr(8'h12, {code[2], code[3]});
         host.wr(8'h13, r13);
         settle();
         chk_route();
         chk({first_left_diff, adc_left_power}, {r13[7], r13[2]});
         rd(8'h11, {code[0], code[1]});
         rd(8'h12, {code[2], code[3]});
         rd(8'h13, r13);
      end
      // unmapped address: write dropped, read answers zero, no aliasing
      host.wr(8'h14, 8'h5a);
      rd(8'h14, 8'h00);
      rd(8'h11, {code[0], code[1]});
      // stepping every sample: ramps to target and stops there
      host.wr(8'h13, 8'h7c);
      @(posedge clock);
      gain_target <= 7'h03;
      for (int k = 1; k < 5; k++) tick(7'(k < 3 ? k : 3));
      @(posedge clock);
      gain_target <= 7'h01;
      tick(7'h02);
      tick(7'h01);
      // stepping off: gain follows target at once
      for (int m = 2; m < 4; m++) begin
         host.wr(8'h13, {6'h1f, 2'(m)});
         @(posedge clock);
         gain_target <= 7'($urandom);
         settle();
         chk(gain_applied, gain_target);
      end
      @(posedge clock);
      gain_target <= 7'h06;
      settle();
      // every second sample: only each second tick moves the gain
      host.wr(8'h13, 8'h7d);
      @(posedge clock);
      gain_target <= 7'h02;
      tick(7'h06);
      tick(7'h05);
      tick(7'h05);
      tick(7'h04);
      @(posedge clock);
      gain_target <= 7'h09;
      tick_pair(7'h05);
      settle();
      chk(exp_q.size(), 32'h0);
      give_verdict();
   end
endmodule : aimr_regs_tb_top
